// ==== hw/mirror_array.sv ====
`timescale 1ns/1ps
module mirror_array
   import mirror_array_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // link from the controller
   mirror_link_if.array_end link,
   // mirror observation, coordinates include the border
   input wire logic [COL_W-1:0] view_col_i,
   input wire logic [ROW_W-1:0] view_row_i,
   output logic view_tilt_o,
   output logic view_landed_o,
   output logic [ROW_W-1:0] view_xhalf_o,
   // status
   output logic pulsing_o,
   output logic landed_o
);

   typedef enum logic [1:0] {D_IDLE, D_LOAD, D_PULSE} dev_state_type;

   typedef struct packed {
      dev_state_type st;
      logic [FRAME_W-1:0] shift;
      logic [3:0] nbits;
      logic [COL_W-1:0] col;
      logic [BEAT_CNT_W-1:0] beat;
      logic [BUF_W-1:0] colbuf;
      logic [COL_W-1:0] walk;
      logic landed;
      logic view_tilt;
      logic view_landed;
      logic [ROW_W-1:0] view_xhalf;
   } dev_regs_type;

   dev_regs_type r;
   dev_regs_type next_r;

   // cell array and the mirror positions it drives
   logic [NUM_ROWS-1:0] cells [NUM_COLS];
   logic [NUM_ROWS-1:0] mirrors [NUM_COLS];

   logic [FRAME_W-1:0] frame;
   logic frame_done;
   op_type frame_op;
   logic [COL_W-1:0] frame_col;
   logic cell_we;
   logic [NUM_ROWS-1:0] cell_wdata;
   logic in_border;
   logic [COL_W-1:0] act_col;
   logic [ROW_W-1:0] act_row;
   logic mirror_bit;

   always_comb
   begin
      frame = {r.shift[FRAME_W-2:0], link.cmd_bit};
      frame_done = link.cmd_sel && (r.nbits == FRAME_LAST);
      frame_op = op_type'(frame[FRAME_W-1 -: 2]);
      frame_col = frame[COL_W-1:0];
   end

   // border is outside the addressable range
   always_comb
   begin
      in_border = (view_col_i < COL_W'(BORDER_W))
         || (view_col_i >= COL_W'(NUM_COLS + BORDER_W))
         || (view_row_i < ROW_W'(BORDER_W))
         || (view_row_i >= ROW_W'(NUM_ROWS + BORDER_W));
      act_col = '0;
      act_row = '0;
      mirror_bit = TILT_NEG;
      if (!in_border)
      begin
         act_col = view_col_i - COL_W'(BORDER_W);
         act_row = view_row_i - ROW_W'(BORDER_W);
         mirror_bit = mirrors[act_col][act_row];
      end
   end

   always_comb
   begin
      next_r = r;
      cell_we = 1'h0;
      cell_wdata = r.colbuf[NUM_ROWS-1:0];

      // serial frame shifter; dropping select abandons a partial frame
      if (link.cmd_sel)
      begin
         next_r.shift = frame;
         next_r.nbits = frame_done ? 4'h0 : r.nbits + 4'h1;
      end
      else
      begin
         next_r.nbits = 4'h0;
      end

      unique case (r.st)
         D_IDLE:
         begin
            if (frame_done)
            begin
               unique case (frame_op)
                  OP_WRITE:
                  begin
                     // an out-of-range column is dropped, not wrapped
                     if (frame_col <= COL_LAST)
                     begin
                        next_r.col = frame_col;
                        next_r.beat = '0;
                        next_r.colbuf = '0;
                        next_r.st = D_LOAD;
                     end
                  end
                  OP_CLOCK:
                  begin
                     next_r.walk = '0;
                     next_r.st = D_PULSE;
                  end
                  OP_PARK:
                  begin
                     next_r.landed = 1'h0;
                  end
                  OP_NOP:
                  begin
                     next_r.st = D_IDLE;
                  end
               endcase
            end
         end
         D_LOAD:
         begin
            // frames seen mid-column are ignored
            if (link.data_valid)
            begin
               next_r.colbuf[int'(r.beat) * BEAT_W +: BEAT_W] =
                  {link.data_fall, link.data_rise};
               next_r.beat = r.beat + BEAT_CNT_W'(1);
               if (r.beat == BEAT_LAST)
               begin
                  cell_we = 1'h1;
                  cell_wdata = next_r.colbuf[NUM_ROWS-1:0];
                  next_r.st = D_IDLE;
               end
            end
         end
         D_PULSE:
         begin
            // one column per cycle; writes and frames are ignored until done
            next_r.walk = r.walk + COL_W'(1);
            if (r.walk == COL_LAST)
            begin
               next_r.landed = 1'h1;
               next_r.st = D_IDLE;
            end
         end
      endcase

      // landed mirrors set tilt; parked mirrors report negative as safe
      next_r.view_landed = in_border || r.landed;
      if (in_border)
      begin
         next_r.view_tilt = TILT_NEG;
      end
      else if (r.landed)
      begin
         next_r.view_tilt = mirror_bit ? TILT_POS : TILT_NEG;
      end
      else
      begin
         next_r.view_tilt = TILT_NEG;
      end
      // horizontal position in half-pixel units
      next_r.view_xhalf = ROW_W'({view_col_i, 1'h0}) + ROW_W'(view_row_i[0]);
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

   // arrays carry no reset; the controller fills every column first
   always_ff @(posedge clk_i)
   begin
      if (cell_we)
      begin
         cells[r.col] <= cell_wdata;
      end
      if (r.st == D_PULSE)
      begin
         mirrors[r.walk] <= cells[r.walk];
      end
   end

   assign link.busy = (r.st == D_PULSE);
   assign view_tilt_o = r.view_tilt;
   assign view_landed_o = r.view_landed;
   assign view_xhalf_o = r.view_xhalf;
   assign pulsing_o = (r.st == D_PULSE);
   assign landed_o = r.landed;

endmodule

// ==== hw/mirror_array_pkg.sv ====
package mirror_array_pkg;

   // array geometry
   localparam int NUM_COLS = 912;
   localparam int NUM_ROWS = 1140;
   localparam int BORDER_W = 10;
   localparam int COL_W = 10;
   localparam int ROW_W = 11;

   // link: two 24-bit words per clock, rising then falling half
   localparam int BUS_W = 24;
   localparam int BEAT_W = 2 * BUS_W;
   localparam int BEATS_PER_COL = (NUM_ROWS + BEAT_W - 1) / BEAT_W;
   localparam int BUF_W = BEATS_PER_COL * BEAT_W;
   localparam int BEAT_CNT_W = 5;
   localparam logic [BEAT_CNT_W-1:0] BEAT_LAST = BEAT_CNT_W'(BEATS_PER_COL - 1);
   localparam logic [COL_W-1:0] COL_LAST = COL_W'(NUM_COLS - 1);

   // serial command frame: opcode then column, msb first
   localparam int FRAME_W = 12;
   localparam logic [3:0] FRAME_LAST = 4'(FRAME_W - 1);
   typedef enum logic [1:0] {OP_NOP, OP_WRITE, OP_CLOCK, OP_PARK} op_type;

   // mirror tilt encoding
   localparam logic TILT_POS = 1'h1;
   localparam logic TILT_NEG = 1'h0;

   // pattern pacing
   localparam int CLK_HZ = 100_000_000;
   localparam int STREAM_RATE_HZ = 2880;
   localparam int BURST_RATE_HZ = 4220;
   localparam int STREAM_PERIOD_CYC = (CLK_HZ + STREAM_RATE_HZ - 1) / STREAM_RATE_HZ;
   localparam int BURST_PERIOD_CYC = (CLK_HZ + BURST_RATE_HZ - 1) / BURST_RATE_HZ;
   localparam int BURST_MAX = 48;
   localparam int TIMER_W = 16;
   localparam int CNT_W = 6;
   localparam logic [3:0] CLK_GUARD = 4'h3;

endpackage

// ==== hw/mirror_link_if.sv ====
`timescale 1ns/1ps
interface mirror_link_if
   import mirror_array_pkg::*;
();
   logic cmd_sel;
   logic cmd_bit;
   logic [BUS_W-1:0] data_rise;
   logic [BUS_W-1:0] data_fall;
   logic data_valid;
   logic busy;

   modport array_end (
      input cmd_sel,
      input cmd_bit,
      input data_rise,
      input data_fall,
      input data_valid,
      output busy
   );

   modport ctrl_end (
      output cmd_sel,
      output cmd_bit,
      output data_rise,
      output data_fall,
      output data_valid,
      input busy
   );
endinterface

// ==== hw/mirror_controller.sv ====
`timescale 1ns/1ps
module mirror_controller
   import mirror_array_pkg::*;
#(
   parameter int STREAM_PERIOD = STREAM_PERIOD_CYC,
   parameter int BURST_PERIOD = BURST_PERIOD_CYC
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // link to the array
   mirror_link_if.ctrl_end link,
   // control
   input wire logic run_i,
   input wire logic burst_mode_i,
   input wire logic [CNT_W-1:0] burst_len_i,
   input wire logic park_i,
   // pattern source, one 48-bit beat per transfer
   input wire logic [BEAT_W-1:0] src_data_i,
   input wire logic src_valid_i,
   output logic src_ready_o,
   // status
   output logic pattern_done_o,
   output logic [CNT_W-1:0] pattern_count_o,
   output logic busy_o
);

   typedef enum logic [2:0] {C_IDLE, C_CMD, C_DATA, C_CLK_WAIT} ctl_state_type;

   typedef struct packed {
      ctl_state_type st;
      op_type op;
      logic [FRAME_W-1:0] frame;
      logic [3:0] nbits;
      logic [COL_W-1:0] col;
      logic [BEAT_CNT_W-1:0] beat;
      logic [TIMER_W-1:0] timer;
      logic [CNT_W-1:0] count;
      logic sel;
      logic cbit;
      logic [BUS_W-1:0] rise;
      logic [BUS_W-1:0] fall;
      logic dvalid;
      logic done;
   } ctl_regs_type;

   ctl_regs_type r;
   ctl_regs_type next_r;
   logic [CNT_W-1:0] limit;
   logic may_start;

   always_comb
   begin
      limit = (burst_len_i > CNT_W'(BURST_MAX)) ? CNT_W'(BURST_MAX) : burst_len_i;
      may_start = run_i && (r.timer == '0)
         && (!burst_mode_i || (r.count < limit));
   end

   always_comb
   begin
      next_r = r;
      next_r.sel = 1'h0;
      next_r.cbit = 1'h0;
      next_r.dvalid = 1'h0;
      next_r.done = 1'h0;
      if (r.timer != '0)
      begin
         next_r.timer = r.timer - TIMER_W'(1);
      end
      if (!run_i)
      begin
         next_r.count = '0;
      end

      unique case (r.st)
         C_IDLE:
         begin
            if (may_start)
            begin
               // every pattern rewrites all columns before its pulse
               next_r.timer = burst_mode_i ? TIMER_W'(BURST_PERIOD - 1)
                  : TIMER_W'(STREAM_PERIOD - 1);
               next_r.col = '0;
               next_r.op = OP_WRITE;
               next_r.frame = {OP_WRITE, COL_W'(0)};
               next_r.st = C_CMD;
            end
            else if (park_i)
            begin
               next_r.op = OP_PARK;
               next_r.frame = {OP_PARK, COL_W'(0)};
               next_r.st = C_CMD;
            end
         end
         C_CMD:
         begin
            next_r.sel = 1'h1;
            next_r.cbit = r.frame[FRAME_W-1];
            next_r.frame = {r.frame[FRAME_W-2:0], 1'h0};
            next_r.nbits = r.nbits + 4'h1;
            if (r.nbits == FRAME_LAST)
            begin
               next_r.nbits = 4'h0;
               unique case (r.op)
                  OP_WRITE:
                  begin
                     next_r.beat = '0;
                     next_r.st = C_DATA;
                  end
                  OP_CLOCK:
                  begin
                     next_r.st = C_CLK_WAIT;
                  end
                  OP_PARK, OP_NOP:
                  begin
                     next_r.st = C_IDLE;
                  end
               endcase
            end
         end
         C_DATA:
         begin
            if (src_valid_i)
            begin
               next_r.rise = src_data_i[BUS_W-1:0];
               next_r.fall = src_data_i[BEAT_W-1:BUS_W];
               next_r.dvalid = 1'h1;
               next_r.beat = r.beat + BEAT_CNT_W'(1);
               if (r.beat == BEAT_LAST)
               begin
                  next_r.st = C_CMD;
                  if (r.col == COL_LAST)
                  begin
                     // pulse only after the last column is loaded
                     next_r.op = OP_CLOCK;
                     next_r.frame = {OP_CLOCK, COL_W'(0)};
                  end
                  else
                  begin
                     next_r.col = r.col + COL_W'(1);
                     next_r.frame = {OP_WRITE, r.col + COL_W'(1)};
                  end
               end
            end
         end
         C_CLK_WAIT:
         begin
            // guard covers the array seeing the frame before busy rises
            if (r.nbits != CLK_GUARD)
            begin
               next_r.nbits = r.nbits + 4'h1;
            end
            else if (!link.busy)
            begin
               next_r.nbits = 4'h0;
               next_r.done = 1'h1;
               next_r.count = r.count + CNT_W'(1);
               next_r.st = C_IDLE;
            end
         end
         default:
         begin
            next_r.st = C_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign link.cmd_sel = r.sel;
   assign link.cmd_bit = r.cbit;
   assign link.data_rise = r.rise;
   assign link.data_fall = r.fall;
   assign link.data_valid = r.dvalid;
   assign src_ready_o = (r.st == C_DATA);
   assign pattern_done_o = r.done;
   assign pattern_count_o = r.count;
   assign busy_o = (r.st != C_IDLE);

endmodule

// ==== test/mirror_link_props.sv ====
`timescale 1ns/1ps
module mirror_link_props
   import mirror_array_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // link signals
   input wire logic cmd_sel,
   input wire logic cmd_bit,
   input wire logic [BUS_W-1:0] data_rise,
   input wire logic [BUS_W-1:0] data_fall,
   input wire logic data_valid,
   input wire logic busy,
   // array status
   input wire logic landed_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   logic [10:0] sr;
   logic [3:0] n;
   logic [4:0] beats;
   logic [9:0] wcnt;
   logic [9:0] ncol;
   logic park_req;
   logic fdone;
   logic clk_fd;
   logic [1:0] fop;

   assign fdone = cmd_sel && n == FRAME_LAST;
   assign fop = sr[10:9];
   assign clk_fd = fdone && fop == 2'h2;

   // shadow of the serial decoder, so frames are judged from the wire alone
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sr <= '0;
         n <= '0;
         beats <= '0;
         wcnt <= '0;
         ncol <= '0;
         park_req <= 1'b0;
      end
      else
      begin
         sr <= {sr[9:0], cmd_bit};
         n <= (cmd_sel && !fdone) ? n + 4'h1 : 4'h0;
         beats <= (fdone && fop == 2'h1) ? 5'h0 : beats + 5'(data_valid);
         wcnt <= busy ? wcnt + 10'h1 : 10'h0;
         // write frames since the last clock frame
         ncol <= clk_fd ? 10'h0 : ncol + 10'(fdone && fop == 2'h1);
         if (fdone)
            park_req <= fop == 2'h3;
      end
   end

   frame_whole_a: assert property ($rose(cmd_sel) |-> cmd_sel[*8] ##1 cmd_sel[*4])
      else $error("serial frame cut short");
   sel_no_data_a: assert property (cmd_sel |-> !data_valid)
      else $error("data beat during serial frame");
   col_beats_a: assert property (fdone && fop == 2'h1 |-> beats == 5'h0 || beats == 5'(BEATS_PER_COL))
      else $error("column not sent whole");
   pulse_load_a: assert property (clk_fd |-> beats == 5'(BEATS_PER_COL) ##[1:3] busy)
      else $error("pulse without loaded column or no walk");
   col_count_a: assert property (clk_fd |-> ncol == 10'(NUM_COLS))
      else $error("pulse before every column written");
   busy_cause_a: assert property ($rose(busy) |-> $past(clk_fd) || $past(clk_fd, 2))
      else $error("walk started without clock frame");
   walk_len_a: assert property ($fell(busy) |-> wcnt == 10'(NUM_COLS))
      else $error("walk length wrong");
   quiet_walk_a: assert property (busy |-> !data_valid && !cmd_sel)
      else $error("traffic during walk");
   land_cause_a: assert property ($rose(landed_o) |-> $past(busy) || $past(busy, 2))
      else $error("mirrors landed without pulse");
   park_drop_a: assert property (fdone && fop == 2'h3 |-> ##[1:4] !landed_o)
      else $error("park frame did not unland");
   unpark_a: assert property ($fell(landed_o) |-> park_req)
      else $error("mirrors unlanded without park");

   cover property (clk_fd);
   cover property ($fell(busy));
   cover property ($fell(landed_o));
   cover property (fdone && fop == 2'h1);
endmodule

// ==== test/micromirror_array_update_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module micromirror_array_update_tb;
   import mirror_array_pkg::*;
   localparam int N = NUM_COLS * BEATS_PER_COL;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic run_i = 1'b0;
   logic burst_mode_i = 1'b0;
   logic [CNT_W-1:0] burst_len_i = '0;
   logic park_i = 1'b0;
   logic [BEAT_W-1:0] src_data_i = '0;
   logic src_valid_i = 1'b0;
   logic src_ready_o, pattern_done_o, busy_o, view_tilt_o, view_landed_o, pulsing_o, landed_o;
   logic [CNT_W-1:0] pattern_count_o;
   logic [COL_W-1:0] view_col_i = '0;
   logic [ROW_W-1:0] view_row_i = '0;
   logic [ROW_W-1:0] view_xhalf_o;
   logic [BEAT_W-1:0] pat [N];
   logic [ROW_W+1:0] exp_q [$];
   logic [ROW_W+1:0] exp_v;
   logic probe_pend = 1'b0;
   logic pend_d = 1'b0;
   int idx = 0;
   int pulse_n = 0;
   int k;
   int err_count = 0;
   int total_checks = 0;

   always #5 clk_i = ~clk_i;

   mirror_link_if link ();
   mirror_controller #(.STREAM_PERIOD(8), .BURST_PERIOD(8)) mirror_controller_i (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .link(link), .run_i(run_i), .burst_mode_i(burst_mode_i), .burst_len_i(burst_len_i),
      .park_i(park_i), .src_data_i(src_data_i), .src_valid_i(src_valid_i), .src_ready_o(src_ready_o),
      .pattern_done_o(pattern_done_o), .pattern_count_o(pattern_count_o), .busy_o(busy_o));
   mirror_array mirror_array_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link), .view_col_i(view_col_i),
      .view_row_i(view_row_i), .view_tilt_o(view_tilt_o), .view_landed_o(view_landed_o),
      .view_xhalf_o(view_xhalf_o), .pulsing_o(pulsing_o), .landed_o(landed_o));
   mirror_link_props props_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_sel(link.cmd_sel), .cmd_bit(link.cmd_bit),
      .data_rise(link.data_rise), .data_fall(link.data_fall), .data_valid(link.data_valid), .busy(link.busy),
      .landed_o(landed_o));

   // second pattern is the inverse of the first, so every cell must flip
   function automatic logic [BEAT_W-1:0] beat(int i);
      return i < N ? pat[i] : ~pat[i - N];
   endfunction

   // source holds a beat until it is taken, with random stalls
   always @(posedge clk_i)
   begin
      k = idx + int'(src_valid_i && src_ready_o);
      idx <= k;
      if (!src_valid_i || src_ready_o)
      begin
         src_valid_i <= rst_n_i && k < 2 * N && $urandom % 8 != 0;
         src_data_i <= beat(k);
      end
   end

   always @(posedge clk_i)
   begin
      if (pend_d)
      begin
         exp_v = exp_q.pop_front();
         `CHK("view", exp_v, {view_tilt_o, view_landed_o, view_xhalf_o})
      end
      pend_d <= probe_pend;
      if (pulsing_o === 1'b1)
         pulse_n <= pulse_n + 1;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // w == 0 waits for a finished pattern, otherwise for w beats taken
   task automatic waitc(int w, int lim);
      for (int i = 0; i < lim && !(w == 0 ? pattern_done_o === 1'b1 : idx >= w); i++)
      begin
         @(posedge clk_i);
         #1;
      end
      if (!(w == 0 ? pattern_done_o === 1'b1 : idx >= w))
      begin
         err_count++;
         $display("CHECK FAILED wait %0d exp 1 got 0", w);
         finish_test();
      end
   endtask

   task automatic probe(int c, int r, logic t, logic l);
      @(posedge clk_i);
      view_col_i <= COL_W'(c);
      view_row_i <= ROW_W'(r);
      exp_q.push_back({t, l, ROW_W'(2 * c + r % 2)});
      probe_pend <= 1'b1;
      @(posedge clk_i);
      probe_pend <= 1'b0;
      @(posedge clk_i);
      #1;
   endtask

   // mode 0 parked, 1 first pattern, 2 inverted pattern
   task automatic check_pts(int mode);
      int c;
      int r;
      logic t;
      for (int i = 0; i < 6; i++)
      begin
         c = i == 0 ? 0 : i == 1 ? NUM_COLS - 1 : $urandom % NUM_COLS;
         r = i == 0 ? 0 : i == 1 ? NUM_ROWS - 1 : $urandom % NUM_ROWS;
         t = pat[c * BEATS_PER_COL + r / BEAT_W][r % BEAT_W] ^ (mode == 2);
         probe(c + BORDER_W, r + BORDER_W, mode != 0 && t, mode != 0);
      end
      probe(0, 0, 1'b0, 1'b1);
      probe(NUM_COLS + 2 * BORDER_W - 1, NUM_ROWS + 2 * BORDER_W - 1, 1'b0, 1'b1);
      probe(BORDER_W - 1, 501, 1'b0, 1'b1);
   endtask

   initial
   begin
      void'($urandom(32'h52d2));
      foreach (pat[i])
         pat[i] = BEAT_W'({$urandom, $urandom});
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      check_pts(0);
      $display("test reset done");
      @(posedge clk_i);
      run_i <= 1'b1;
      waitc(1, 2000);
      @(posedge clk_i);
      run_i <= 1'b0;
      waitc(0, 45000);
      repeat (3) @(posedge clk_i);
      #1;
      `CHK("landed", 1'b1, landed_o)
      `CHK("pulse cycles", NUM_COLS, pulse_n)
      check_pts(1);
      $display("test stream done");
      @(posedge clk_i);
      burst_mode_i <= 1'b1;
      burst_len_i <= CNT_W'(1);
      run_i <= 1'b1;
      waitc(N + 2000, 10000);
      check_pts(1);
      waitc(0, 45000);
      repeat (50) @(posedge clk_i);
      #1;
      `CHK("count", CNT_W'(1), pattern_count_o)
      `CHK("busy", 1'b0, busy_o)
      `CHK("pulse cycles", 2 * NUM_COLS, pulse_n)
      check_pts(2);
      $display("test burst done");
      @(posedge clk_i);
      park_i <= 1'b1;
      @(posedge clk_i);
      park_i <= 1'b0;
      repeat (30) @(posedge clk_i);
      #1;
      `CHK("landed", 1'b0, landed_o)
      check_pts(0);
      $display("test park done");
      finish_test();
   end
endmodule
